// file: hw/rt_opt_cfg.svh
// Offsets, field positions, reset values and widths of the option bank
`ifndef RT_OPT_CFG_SVH
`define RT_OPT_CFG_SVH
`define RT_OPT_ADDR_W     12
`define RT_OPT_OFS        12'h000
`define RT_STAT_OFS       12'h004
`define RT_OPT_W          4
`define RT_OPT_RESET      4'h0
`define RT_UNDEF_INV_BIT  3
`define RT_BCAST_SEP_BIT  2
`define RT_SIMPLE_BIT     1
`define RT_SSTROBE_BIT    0
`define RT_STAT_RESP_BIT  4
`define RT_STAT_ERR_BIT   5
`define RT_STAT_IGN_BIT   6
`define RT_STAT_B8_BIT    7
`define RT_STAT_HI_BIT    8
`define RT_RESP_OKAY      2'h0
`define RT_RESP_SLVERR    2'h2
`define RT_MC_LAST_LOW    5'h0f
`endif

// file: hw/rt_opt_pkg.sv
// Types and decode helpers shared by the option bank and the mode classifier
package rt_opt_pkg;
  // Write channel states
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } wr_state_e;
  // Read channel states
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_e;
  // True for the mode codes that the undefined-code option governs
  function automatic logic is_undefined_mode(input logic [4:0] mc, input logic tr);
    logic rx_set;
    logic tx_set;
    rx_set = (mc <= 5'h0f) || (mc == 5'h10) || (mc == 5'h12) || (mc == 5'h13);
    tx_set = (mc == 5'h11) || (mc == 5'h14) || (mc == 5'h15);
    return (rx_set && !tr) || (tx_set && tr);
  endfunction : is_undefined_mode
endpackage : rt_opt_pkg

// file: hw/mode_cls_if.sv
// Carrier between the option bank and the mode command classifier
`timescale 1ns/1ps
interface mode_cls_if;
  logic       opt_undef_inv;   // Undefined mode codes ignored
  logic       opt_bcast_sep;   // Broadcast data kept apart
  logic       opt_simple;      // Simplified mode command handling
  logic       cmd_valid;       // One-cycle command pulse
  logic [4:0] cmd_mode_code;   // Mode code field
  logic       cmd_tr;          // Transmit/receive bit
  logic       cmd_bcast;       // Broadcast command
  logic       cmd_illegal;     // Legality entry says illegal
  logic       res_valid;       // Result pulse
  logic       res_recognized;  // Command recognised
  logic       res_status;      // Status word transmitted
  logic       res_data_word;   // Data word follows status
  logic       res_msg_error;   // Message error status set
  logic       res_stat_upd;    // Status kept for later report
  logic       res_simple;      // Simplified handling applied
  logic       res_bcast_buf;   // Data goes to broadcast buffer
  logic       res_undefined;   // Command was an undefined mode code
  modport eng (output opt_undef_inv, opt_bcast_sep, opt_simple, cmd_valid, cmd_mode_code,
               cmd_tr, cmd_bcast, cmd_illegal,
               input res_valid, res_recognized, res_status, res_data_word, res_msg_error,
               res_stat_upd, res_simple, res_bcast_buf, res_undefined);
  modport cls (input opt_undef_inv, opt_bcast_sep, opt_simple, cmd_valid, cmd_mode_code,
               cmd_tr, cmd_bcast, cmd_illegal,
               output res_valid, res_recognized, res_status, res_data_word, res_msg_error,
               res_stat_upd, res_simple, res_bcast_buf, res_undefined);
endinterface : mode_cls_if

// file: hw/rt_mode_classify.sv
// Mode command classifier driven by the option bits
`timescale 1ns/1ps
`include "rt_opt_cfg.svh"
module rt_mode_classify (
  input wire logic aclk,     // System clock
  input wire logic aresetn,  // Synchronous reset, active low
  input wire logic ce,       // Clock enable, freezes state when low
  mode_cls_if.cls  mc        // Commands in, decisions out
);
  // Combinational decision terms
  wire undef_w   = rt_opt_pkg::is_undefined_mode(mc.cmd_mode_code, mc.cmd_tr);
  wire ignore_w  = undef_w && mc.opt_undef_inv;
  wire recog_w   = !ignore_w;
  wire err_w     = recog_w && mc.cmd_illegal;
  // Only a legal transmit mode code of 16 and up carries a data word
  wire data_w    = recog_w && !mc.cmd_illegal && !mc.cmd_bcast && mc.cmd_tr &&
                   (mc.cmd_mode_code > `RT_MC_LAST_LOW);
  wire status_w  = recog_w && !mc.cmd_bcast;
  wire simple_w  = recog_w && mc.opt_simple;
  wire bbuf_w    = mc.cmd_bcast && mc.opt_bcast_sep;

  // Result flops; reloaded from cmd_valid each enabled cycle, so res_valid is a pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mc.res_valid      <= 1'b0;
      mc.res_recognized <= 1'b0;
      mc.res_status     <= 1'b0;
      mc.res_data_word  <= 1'b0;
      mc.res_msg_error  <= 1'b0;
      mc.res_stat_upd   <= 1'b0;
      mc.res_simple     <= 1'b0;
      mc.res_bcast_buf  <= 1'b0;
      mc.res_undefined  <= 1'b0;
    end else if (ce) begin
      mc.res_valid      <= mc.cmd_valid;
      mc.res_recognized <= mc.cmd_valid && recog_w;
      mc.res_status     <= mc.cmd_valid && status_w;
      mc.res_data_word  <= mc.cmd_valid && data_w;
      mc.res_msg_error  <= mc.cmd_valid && err_w;
      mc.res_stat_upd   <= mc.cmd_valid && recog_w;
      mc.res_simple     <= mc.cmd_valid && simple_w;
      mc.res_bcast_buf  <= mc.cmd_valid && bbuf_w;
      mc.res_undefined  <= mc.cmd_valid && undef_w;
    end
  end

  // Ignored commands raise no recognition, status, status update or error
  chk_ignore_silent: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && mc.cmd_valid && ignore_w) |=>
      !mc.res_recognized && !mc.res_status && !mc.res_stat_upd && !mc.res_msg_error)
    else $error("ignored undefined mode code produced activity");
  // Illegal recognised command: error status, never a data word
  chk_illegal_err: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && mc.cmd_valid && recog_w && mc.cmd_illegal) |=>
      mc.res_msg_error && !mc.res_data_word && (mc.res_status == !$past(mc.cmd_bcast)))
    else $error("illegal mode command answered wrongly");
endmodule : rt_mode_classify

// file: hw/rt_mode_opt_bank.sv
// Option bits for mode code handling, broadcast storage and byte reads, on AXI4-Lite
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "rt_opt_cfg.svh"
module rt_mode_opt_bank #(
  parameter int  ADDR_W           = `RT_OPT_ADDR_W,  // AXI address width
  parameter bit  PARALLEL_VARIANT = 1'b1             // Parallel host bus build
) (
  input  wire logic              aclk,                  // System clock, 125 MHz
  input  wire logic              aresetn,               // Synchronous reset, active low
  input  wire logic              ce,                    // Clock enable
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,          // Write address
  input  wire logic              s_axi_awvalid,         // Write address valid
  output wire logic              s_axi_awready,         // Write address ready
  input  wire logic [31:0]       s_axi_wdata,           // Write data
  input  wire logic [3:0]        s_axi_wstrb,           // Write byte strobes
  input  wire logic              s_axi_wvalid,          // Write data valid
  output wire logic              s_axi_wready,          // Write data ready
  output wire logic [1:0]        s_axi_bresp,           // Write response
  output wire logic              s_axi_bvalid,          // Write response valid
  input  wire logic              s_axi_bready,          // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,          // Read address
  input  wire logic              s_axi_arvalid,         // Read address valid
  output wire logic              s_axi_arready,         // Read address ready
  output wire logic [31:0]       s_axi_rdata,           // Read data
  output wire logic [1:0]        s_axi_rresp,           // Read response
  output wire logic              s_axi_rvalid,          // Read data valid
  input  wire logic              s_axi_rready,          // Read data ready
  input  wire logic              master_reset_pin_n,    // Master reset pin, active low
  input  wire logic              cmd_valid,             // Mode command pulse from engine
  input  wire logic [4:0]        cmd_mode_code,         // Mode code field
  input  wire logic              cmd_tr,                // Transmit/receive bit
  input  wire logic              cmd_bcast,             // Broadcast command
  input  wire logic              cmd_illegal,           // Legality entry illegal
  output wire logic              rsp_valid,             // Decision pulse
  output wire logic              rsp_recognized,        // Command recognised
  output wire logic              rsp_status,            // Send status word
  output wire logic              rsp_data_word,         // Send data word
  output wire logic              rsp_msg_error,         // Set message error
  output wire logic              rsp_status_update,     // Keep status for later report
  output wire logic              rsp_simple_proc,       // Use simplified handling
  output wire logic              rx_bcast_buffer,       // Store data in broadcast buffer
  output wire logic              opt_undef_invalid,     // Option level to engine
  output wire logic              opt_bcast_separate,    // Option level to engine
  output wire logic              opt_simple_mode,       // Option level to engine
  input  wire logic              host_rd_en_n,          // Host read strobe pin, active low
  input  wire logic              low_byte_address_bit,  // Host address bit 0 pin
  input  wire logic              host_bus_8bit,         // Host bus width strap pin
  input  wire logic [15:0]       mem_rd_word,           // Word being read by host
  output wire logic [7:0]        host_rd_byte,          // Byte presented to host
  output wire logic              host_rd_hi_lane        // High byte selected
);
  // Option register and its decoded fields
  logic [`RT_OPT_W-1:0] opt_r;   // Four option bits
  logic [`RT_OPT_W-1:0] opt_nxt; // Next option value
  wire undefined_mode_invalid  = opt_r[`RT_UNDEF_INV_BIT];
  wire broadcast_data_separate = opt_r[`RT_BCAST_SEP_BIT];
  wire simple_mode_cmd_proc    = opt_r[`RT_SIMPLE_BIT];
  wire single_strobe_byte_read = opt_r[`RT_SSTROBE_BIT];

  // Pin synchronisers: stage one is read only by stage two
  logic [3:0] pin_s1_r;  // First stage
  logic [3:0] pin_s2_r;  // Second stage
  wire  [3:0] pin_raw = {master_reset_pin_n, host_bus_8bit, low_byte_address_bit,
                         host_rd_en_n};
  wire        mr_n_s    = pin_s2_r[3];
  wire        bus8_s    = pin_s2_r[2];
  wire        a0_s      = pin_s2_r[1];
  wire        rd_active = !pin_s2_r[0];

  // Two flops per pin, frozen with the clock enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 4'hf;
      pin_s2_r <= 4'hf;
    end else if (ce) begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  // AXI write channel: address and data taken in either order
  rt_opt_pkg::wr_state_e wr_st_r;    // Write state
  logic                  aw_held_r;  // Address captured
  logic                  w_held_r;   // Data captured
  logic [ADDR_W-1:0]     awaddr_r;   // Captured address
  logic [31:0]           wdata_r;    // Captured data
  logic                  wstrb0_r;   // Low byte lane enabled
  logic [1:0]            bresp_r;    // Stored response
  wire wr_collect = (wr_st_r == rt_opt_pkg::WR_COLLECT);
  wire aw_fire    = s_axi_awvalid && s_axi_awready;
  wire w_fire     = s_axi_wvalid && s_axi_wready;
  wire wr_do      = ce && wr_collect && aw_held_r && w_held_r;
  // Word addresses at full width, so the decode compares equal widths
  localparam logic [ADDR_W-1:0] OPT_ADDR  = ADDR_W'(`RT_OPT_OFS);   // Option word address
  localparam logic [ADDR_W-1:0] STAT_ADDR = ADDR_W'(`RT_STAT_OFS);  // Status word address
  wire wr_opt_hit = (awaddr_r[ADDR_W-1:2] == OPT_ADDR[ADDR_W-1:2]);
  wire wr_sts_hit = (awaddr_r[ADDR_W-1:2] == STAT_ADDR[ADDR_W-1:2]);
  // Ready only while the clock runs, so nothing is taken during a freeze
  assign s_axi_awready = ce && wr_collect && !aw_held_r;
  assign s_axi_wready  = ce && wr_collect && !w_held_r;
  assign s_axi_bvalid  = ce && (wr_st_r == rt_opt_pkg::WR_RESP);
  assign s_axi_bresp   = bresp_r;

  // Capture and response sequencing for writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_r   <= rt_opt_pkg::WR_COLLECT;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= 32'h0;
      wstrb0_r  <= 1'b0;
      bresp_r   <= `RT_RESP_OKAY;
    end else if (ce) begin
      case (wr_st_r)
        rt_opt_pkg::WR_COLLECT: begin
          if (aw_fire) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
          end
          if (w_fire) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb0_r <= s_axi_wstrb[0];
          end
          if (aw_held_r && w_held_r) begin
            // Status word is read-only but mapped, so it answers OKAY
            bresp_r <= (wr_opt_hit || wr_sts_hit) ? `RT_RESP_OKAY : `RT_RESP_SLVERR;
            wr_st_r <= rt_opt_pkg::WR_RESP;
          end
        end
        rt_opt_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            wr_st_r   <= rt_opt_pkg::WR_COLLECT;
          end
        end
        default: wr_st_r <= rt_opt_pkg::WR_COLLECT;
      endcase
    end
  end

  // Option write and master reset; the pin clear outranks a host write
  wire opt_wr = wr_do && wr_opt_hit && wstrb0_r;
  assign opt_nxt = !mr_n_s ? `RT_OPT_RESET :
                   opt_wr  ? s_axi_wdata_low(wdata_r) : opt_r;

  // Option register holds until rewritten or cleared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opt_r <= `RT_OPT_RESET;
    end else if (ce) begin
      opt_r <= opt_nxt;
    end
  end

  // Low option field of a data word
  function automatic logic [`RT_OPT_W-1:0] s_axi_wdata_low(input logic [31:0] d);
    return d[`RT_OPT_W-1:0];
  endfunction : s_axi_wdata_low

  // Classifier link
  mode_cls_if mcl ();
  assign mcl.opt_undef_inv = undefined_mode_invalid;
  assign mcl.opt_bcast_sep = broadcast_data_separate;
  assign mcl.opt_simple    = simple_mode_cmd_proc;
  assign mcl.cmd_valid     = cmd_valid;
  assign mcl.cmd_mode_code = cmd_mode_code;
  assign mcl.cmd_tr        = cmd_tr;
  assign mcl.cmd_bcast     = cmd_bcast;
  assign mcl.cmd_illegal   = cmd_illegal;

  rt_mode_classify rt_mode_classify_inst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .mc      (mcl.cls)
  );

  assign rsp_valid          = mcl.res_valid;
  assign rsp_recognized     = mcl.res_recognized;
  assign rsp_status         = mcl.res_status;
  assign rsp_data_word      = mcl.res_data_word;
  assign rsp_msg_error      = mcl.res_msg_error;
  assign rsp_status_update  = mcl.res_stat_upd;
  assign rsp_simple_proc    = mcl.res_simple;
  assign rx_bcast_buffer    = mcl.res_bcast_buf;
  assign opt_undef_invalid  = undefined_mode_invalid;
  assign opt_bcast_separate = broadcast_data_separate;
  assign opt_simple_mode    = simple_mode_cmd_proc;

  // Last decision kept for software to inspect
  logic [2:0] last_res_r;  // Ignored, error, recognised

  // Sticky copy of the latest classifier result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_res_r <= 3'h0;
    end else if (ce && mcl.res_valid) begin
      last_res_r <= {mcl.res_undefined && !mcl.res_recognized, mcl.res_msg_error,
                     mcl.res_recognized};
    end
  end

  // Byte lane selection for the 8-bit host bus
  logic       rd_active_d_r;  // Strobe level one cycle back
  logic       lane_hi_r;      // High byte selected
  logic [7:0] rd_byte_r;      // Byte on the host bus
  wire single_mode = single_strobe_byte_read && PARALLEL_VARIANT && bus8_s;
  wire rd_fall     = rd_active && !rd_active_d_r;
  // One wide strobe follows the address bit; separate strobes latch it per pulse
  wire lane_nxt    = single_mode ? (rd_active ? a0_s : lane_hi_r) :
                     (rd_fall ? a0_s : lane_hi_r);
  assign host_rd_byte    = rd_byte_r;
  assign host_rd_hi_lane = lane_hi_r;

  // Byte path flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_active_d_r <= 1'b0;
      lane_hi_r     <= 1'b0;
      rd_byte_r     <= 8'h00;
    end else if (ce) begin
      rd_active_d_r <= rd_active;
      lane_hi_r     <= lane_nxt;
      if (rd_active) begin
        rd_byte_r <= lane_nxt ? mem_rd_word[15:8] : mem_rd_word[7:0];
      end
    end
  end

  // AXI read channel
  rt_opt_pkg::rd_state_e rd_st_r;  // Read state
  logic [31:0]           rdata_r;  // Read data
  logic [1:0]            rresp_r;  // Read response
  wire rd_idle    = (rd_st_r == rt_opt_pkg::RD_IDLE);
  wire ar_fire    = s_axi_arvalid && s_axi_arready;
  wire rd_opt_hit = (s_axi_araddr[ADDR_W-1:2] == OPT_ADDR[ADDR_W-1:2]);
  wire rd_sts_hit = (s_axi_araddr[ADDR_W-1:2] == STAT_ADDR[ADDR_W-1:2]);
  // Status shows options, last decision, bus width strap and lane
  wire [31:0] stat_word = {23'h0, lane_hi_r, bus8_s, last_res_r, opt_r};
  wire [31:0] rd_mux    = rd_opt_hit ? {28'h0, opt_r} :
                          rd_sts_hit ? stat_word : 32'h0;
  assign s_axi_arready = ce && rd_idle;
  assign s_axi_rvalid  = ce && (rd_st_r == rt_opt_pkg::RD_DATA);
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Read sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_r <= rt_opt_pkg::RD_IDLE;
      rdata_r <= 32'h0;
      rresp_r <= `RT_RESP_OKAY;
    end else if (ce) begin
      case (rd_st_r)
        rt_opt_pkg::RD_IDLE: begin
          if (ar_fire) begin
            rdata_r <= rd_mux;
            rresp_r <= (rd_opt_hit || rd_sts_hit) ? `RT_RESP_OKAY : `RT_RESP_SLVERR;
            rd_st_r <= rt_opt_pkg::RD_DATA;
          end
        end
        rt_opt_pkg::RD_DATA: begin
          if (s_axi_rready) begin
            rd_st_r <= rt_opt_pkg::RD_IDLE;
          end
        end
        default: rd_st_r <= rt_opt_pkg::RD_IDLE;
      endcase
    end
  end

  // Checks on the option bank
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_write_done;
    ce && opt_wr && mr_n_s;
  endsequence
  sequence s_opt_matches;
    opt_r == $past(wdata_r[`RT_OPT_W-1:0]);
  endsequence

  chk_opt_master_rst: assert property ((ce && !mr_n_s) |=> !opt_r[`RT_UNDEF_INV_BIT])
    else $error("undefined option not cleared by master reset");
  chk_opt_write_lands: assert property (s_write_done |=> s_opt_matches)
    else $error("option write not stored");
  chk_opt_holds: assert property ((ce && mr_n_s && !opt_wr) |=> $stable(opt_r))
    else $error("option bits changed without a write");
  chk_opt_readback: assert property ((ce && ar_fire && rd_opt_hit) |=>
      s_axi_rdata[`RT_OPT_W-1:0] == $past(opt_r) && s_axi_rresp == `RT_RESP_OKAY)
    else $error("option readback wrong");
  chk_bresp_follows: assert property ((ce && wr_collect && aw_held_r && w_held_r) |=>
      (wr_st_r == rt_opt_pkg::WR_RESP))
    else $error("write response not raised");
  chk_single_lane: assert property ((ce && single_mode && rd_active) |=>
      lane_hi_r == $past(a0_s))
    else $error("single strobe lane not following address bit");
  chk_dual_lane_hold: assert property ((ce && !single_mode && rd_active && !rd_fall) |=>
      $stable(lane_hi_r))
    else $error("lane moved inside a separate strobe");
  chk_bcast_buffer: assert property ((ce && cmd_valid) |=>
      rx_bcast_buffer == ($past(cmd_bcast) && $past(broadcast_data_separate)))
    else $error("broadcast buffer choice wrong");
  chk_simple_mode: assert property ((ce && cmd_valid) ##1 rsp_recognized |->
      rsp_simple_proc == $past(simple_mode_cmd_proc))
    else $error("simplified handling not applied");
  chk_legal_inform: assert property ((ce && cmd_valid && !cmd_illegal && !cmd_bcast &&
      !undefined_mode_invalid) |=> rsp_status && rsp_status_update && !rsp_msg_error)
    else $error("legal command not answered in form");
endmodule : rt_mode_opt_bank

// file: verif/host_rd_model.sv
// Host processor model that drives the byte-read strobe and address pins
`timescale 1ns/1ps
module host_rd_model (
  input  wire logic aclk,        // Host side clock
  input  wire logic rd_req,      // Bench asks for a read strobe
  input  wire logic hi_sel,      // Bench asks for the high byte
  output logic      rd_strobe_n, // Read enable pin, active low
  output logic      byte_hi      // Low address bit pin
);
  // Pins move just after an edge, as a real host bus does
  always_ff @(posedge aclk) begin
    rd_strobe_n <= !rd_req;
    byte_hi     <= hi_sel;
  end
endmodule : host_rd_model

// file: verif/tb_rt_mode_opt_bank.sv
// Self-checking bench for the mode code option bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_rt_mode_opt_bank;
  logic        aclk = 0, aresetn = 0, ce = 1, master_reset_pin_n = 1, host_bus_8bit = 1;
  logic        rd_req = 0, hi_sel = 0, cmd_valid = 0, cmd_tr = 0, cmd_bcast = 0, cmd_illegal = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [4:0]  cmd_mode_code = 0;
  logic        rsp_valid, rsp_recognized, rsp_status, rsp_data_word, rsp_msg_error;
  logic        rsp_status_update, rsp_simple_proc, rx_bcast_buffer, host_rd_hi_lane;
  logic        opt_undef_invalid, opt_bcast_separate, opt_simple_mode;
  logic        host_rd_en_n, low_byte_address_bit;
  logic [15:0] mem_rd_word = 16'ha55a;  // High byte a5, low byte 5a
  logic [7:0]  host_rd_byte;
  logic [6:0]  exp_f;                   // Expected decision flags
  logic [4:0]  codes [8] = '{5'h00, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h15, 5'h16};
  logic [3:0]  opts [4] = '{4'h0, 4'h8, 4'h6, 4'he};
  int          err_count = 0, checked = 0;
  rt_mode_opt_bank rt_mode_opt_bank_inst (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .master_reset_pin_n, .cmd_valid, .cmd_mode_code,
    .cmd_tr, .cmd_bcast, .cmd_illegal, .rsp_valid, .rsp_recognized, .rsp_status, .rsp_data_word,
    .rsp_msg_error, .rsp_status_update, .rsp_simple_proc, .rx_bcast_buffer, .opt_undef_invalid,
    .opt_bcast_separate, .opt_simple_mode, .host_rd_en_n, .low_byte_address_bit, .host_bus_8bit,
    .mem_rd_word, .host_rd_byte, .host_rd_hi_lane);
  host_rd_model host_rd_model_inst (.aclk, .rd_req, .hi_sel, .rd_strobe_n(host_rd_en_n),
    .byte_hi(low_byte_address_bit));
  // 125 MHz clock
  initial forever #4 aclk = !aclk;
  // Verdict, shared by the main sequence and the watchdog
  task automatic finish_test();
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  // Tests need well under 50k cycles; a hang ends here
  initial begin
    #400000;
    err_count++;
    finish_test();
  end
  // One AXI4-Lite write or read; handshakes judged from values settled before the edge
  task automatic axi(input logic wr, input logic [11:0] a, input logic [31:0] v,
                     input logic [3:0] s, output logic [1:0] rs, output logic [31:0] rd);
    logic ta, tw, tr;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do begin
      @(negedge aclk);
      ta = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
      tw = s_axi_wvalid && s_axi_wready;
      tr = (s_axi_bready && s_axi_bvalid) || (s_axi_rready && s_axi_rvalid);
      rs = wr ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (ta) s_axi_arvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end while (!tr);
    s_axi_bready <= 0;
    s_axi_rready <= 0;
  endtask : axi
  // One mode command; expected flags worked out from the option bits
  task automatic cmd(input logic [4:0] c, input logic t, b, i, input logic [3:0] o);
    logic       u;
    logic [7:0] got;
    u = ((c <= 5'h0f || c == 5'h10 || c == 5'h12 || c == 5'h13) && !t)
        || ((c == 5'h11 || c == 5'h14 || c == 5'h15) && t);
    exp_f = (u && o[3]) ? {6'h00, b && o[2]}
          : {1'b1, !b, !i && !b && t && c >= 5'h10, i, 1'b1, o[1], b && o[2]};
    @(posedge aclk);
    cmd_valid <= 1;
    cmd_mode_code <= c;
    cmd_tr <= t;
    cmd_bcast <= b;
    cmd_illegal <= i;
    @(posedge aclk);
    cmd_valid <= 0;
    #1;
    got = {rsp_valid, rsp_recognized, rsp_status, rsp_data_word, rsp_msg_error,
           rsp_status_update, rsp_simple_proc, rx_bcast_buffer};
    `CHK("rsp", {1'b1, exp_f}, got)
  endtask : cmd
  // Main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    axi(0, 12'h000, 0, 4'h0, r, d);
    `CHK("opt after reset", 32'h0, d)
    axi(1, 12'h000, 32'h0000000f, 4'hf, r, d);
    axi(1, 12'h000, 32'h00000000, 4'h0, r, d);  // Strobe off: no change
    axi(0, 12'h000, 0, 4'h0, r, d);
    `CHK("opt held", 32'h0000000f, d & 32'h0000000f)
    `CHK("opt levels", 3'h7, {opt_undef_invalid, opt_bcast_separate, opt_simple_mode})
    axi(1, 12'h0f0, 0, 4'hf, r, d);
    `CHK("unmapped bresp", 2'h2, r)
    axi(0, 12'h0f0, 0, 4'h0, r, d);
    `CHK("unmapped rresp", 2'h2, r)
    master_reset_pin_n <= 0;
    repeat (4) @(posedge aclk);
    master_reset_pin_n <= 1;
    axi(0, 12'h000, 0, 4'h0, r, d);
    `CHK("opt after pin reset", 32'h0, d & 32'h0000000f)
    // Four option mixes (0, 8, 6, e) against defined and undefined codes
    foreach (opts[k]) begin
      axi(1, 12'h000, {28'h0, opts[k]}, 4'hf, r, d);
      foreach (codes[j]) for (int m = 0; m < 8; m++) cmd(codes[j], m[2], m[1], m[0], opts[k]);
    end
    // Last command: defined code 22 transmit, broadcast, illegal, options e; pins idle, 8-bit
    axi(0, 12'h004, 0, 4'h0, r, d);
    `CHK("status word", 32'h000000be, d)
    // Byte reads: dual strobe, single strobe, single strobe on a 16-bit bus
    for (int k = 0; k < 3; k++) begin
      axi(1, 12'h000, {31'h0, k != 0}, 4'hf, r, d);
      host_bus_8bit <= (k != 2);
      rd_req <= 0;
      hi_sel <= 0;
      repeat (6) @(posedge aclk);
      rd_req <= 1;
      repeat (6) @(posedge aclk);
      hi_sel <= 1;
      repeat (6) @(negedge aclk);
      `CHK("host byte", (k == 1) ? 8'ha5 : 8'h5a, host_rd_byte)
      `CHK("host lane", (k == 1), host_rd_hi_lane)
    end
    finish_test();
  end
endmodule : tb_rt_mode_opt_bank
